//--- rtl/spi_port_pkg.sv
// constants, offsets and types for the serial peripheral port
package spi_port_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DATA_OFS = 8'h08;
  localparam logic [7:0] PIN_OFS = 8'h0C;
  // control field positions
  localparam int IE_BIT = 7;
  localparam int EN_BIT = 6;
  localparam int ORD_BIT = 5;
  localparam int ROLE_MASTER_SELECT_BIT = 4;
  localparam int POL_BIT = 3;
  localparam int PHA_BIT = 2;
  localparam int RATE_HI_BIT = 1;
  localparam int RATE_LO_BIT = 0;
  // status field positions
  localparam int DONE_BIT = 7;
  localparam int WRITE_COLLISION_FLAG_BIT = 6;
  localparam int DBL_BIT = 0;
  // pin setup field positions
  localparam int DIR_MOSI_BIT = 0;
  localparam int DIR_MISO_BIT = 1;
  localparam int DIR_SCK_BIT = 2;
  localparam int DIR_SS_BIT = 3;
  localparam int SS_VAL_BIT = 4;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] PIN_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // edge count of the last of sixteen clock edges in a byte
  localparam logic [3:0] LAST_EDGE = 4'hF;
  // half serial clock period in system clocks, index {double, rate}
  typedef logic [6:0] half_type;
  localparam half_type HALF_TBL [8] = '{7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20};
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } state_type;
endpackage : spi_port_pkg

//--- rtl/sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

//--- rtl/spi_port.sv
// serial peripheral port, master or slave, with apb register access
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Function
// - slave role: select line is always an input
// - slave selected: active, data out driven only if software enabled it
// - slave deselected: passive, ignores incoming data, data out may stay driven
// - select rising in slave role resets bit counter and shift logic
// - master with select input pulled low means another master selected us
// - on that event clear master bit and set transfer done flag
// - interrupt only when done flag, enable bit and global enable all set
// - no serial activity unless the enable bit is one
// - bit order one sends least significant bit first, zero most first
// - role bit one means master, zero means slave
// - polarity one idles clock high, zero idles clock low
// - phase zero samples leading edge, one samples trailing edge
// - normal speed rate codes give divide by 4, 16, 64, 128
// - double speed rate codes give divide by 2, 8, 32, 64
// - data register write starts a byte transfer
// - done flag clears by vector acknowledge or status read then data access
// - data write during a transfer sets collision flag, cleared only by status read then data access
// - double speed bit sits in status bit 0
module spi_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_i,
  output logic ss_o,
  output logic ss_oe,
  // interrupt handshake with the cpu
  input wire logic global_irq_en,
  input wire logic irq_vector_ack,
  output logic irq
);
  logic [7:0] ctrl_q;
  logic [4:0] pin_q;
  logic dbl_q;
  logic done_q;
  logic write_collision_flag_q;
  logic arm_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic rbit_q;
  logic [3:0] cnt_q;
  spi_port_pkg::state_type state_q;
  logic sck_q;
  logic [6:0] half_q;
  logic ss_p_q;
  logic sck_p_q;
  logic ss_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;

  sync2 #(.WIDTH(4)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({ss_i, sck_i, mosi_i, miso_i}),
    .q({ss_s, sck_s, mosi_s, miso_s})
  );

  // bus decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire hit_ctrl = paddr == spi_port_pkg::CTRL_OFS;
  wire hit_stat = paddr == spi_port_pkg::STAT_OFS;
  wire hit_data = paddr == spi_port_pkg::DATA_OFS;
  wire hit_pin = paddr == spi_port_pkg::PIN_OFS;
  wire mapped = hit_ctrl | hit_stat | hit_data | hit_pin;
  wire data_acc = acc & hit_data;
  wire data_wr = data_acc & pwrite;
  wire stat_rd = acc & hit_stat & ~pwrite;

  // control fields
  wire en = ctrl_q[spi_port_pkg::EN_BIT];
  wire ie = ctrl_q[spi_port_pkg::IE_BIT];
  wire ord = ctrl_q[spi_port_pkg::ORD_BIT];
  wire pol = ctrl_q[spi_port_pkg::POL_BIT];
  wire pha = ctrl_q[spi_port_pkg::PHA_BIT];
  wire [2:0] rate_idx = {dbl_q, ctrl_q[spi_port_pkg::RATE_HI_BIT], ctrl_q[spi_port_pkg::RATE_LO_BIT]};
  wire master_on = en & ctrl_q[spi_port_pkg::ROLE_MASTER_SELECT_BIT];
  wire slave_on = en & ~ctrl_q[spi_port_pkg::ROLE_MASTER_SELECT_BIT];

  // select pulled low while master with select as input
  wire contend = master_on & ~pin_q[spi_port_pkg::DIR_SS_BIT] & ~ss_s;
  wire slave_sel = slave_on & ~ss_s;
  wire ss_rise = slave_on & ss_s & ~ss_p_q;
  wire abort = ~en | contend | ss_rise;

  // clock edge events
  wire shifting = state_q == spi_port_pkg::ST_SHIFT;
  wire m_tick = master_on & shifting & (half_q == 7'h01);
  wire s_tick = slave_sel & (sck_s != sck_p_q);
  wire tick = master_on ? m_tick : s_tick;
  // leading edge is even count, sample edge by phase
  wire lead = ~cnt_q[0];
  wire samp = lead ^ pha;
  wire last = cnt_q == spi_port_pkg::LAST_EDGE;
  wire in_bit = master_on ? miso_s : mosi_s;
  wire first_skip = pha & (cnt_q == 4'h0);
  // sample edges never shift, so data out stays still on them; rx loads on the last edge, which shifts too when phase is zero
  wire do_shift = tick & ~samp & ~first_skip;
  wire shift_in = samp ? in_bit : rbit_q;
  wire [7:0] sh_next = ord ? {shift_in, sh_q[7:1]} : {sh_q[6:0], shift_in};
  wire out_bit = ord ? sh_q[0] : sh_q[7];
  // byte ends on the sixteenth edge
  wire byte_done = tick & last & ~abort;
  wire busy = shifting | (cnt_q != 4'h0);
  // data write starts a transfer when idle
  wire start = data_wr & ~busy & en;
  wire m_start = start & master_on;

  // flags, set wins over clear
  wire clear_ok = data_acc & arm_q;
  wire done_set = byte_done | contend;
  wire write_collision_flag_set = data_wr & busy;
  wire done_d = done_set | (done_q & ~(clear_ok | irq_vector_ack));
  wire write_collision_flag_d = write_collision_flag_set | (write_collision_flag_q & ~clear_ok);
  wire arm_d = stat_rd ? (done_q | write_collision_flag_q) : (data_acc ? 1'b0 : arm_q);

  // contention clears master bit, winning over a write
  wire [7:0] ctrl_w = (wr & hit_ctrl) ? pwdata[7:0] : ctrl_q;
  wire [7:0] ctrl_d = contend ? (ctrl_w & ~(8'h01 << spi_port_pkg::ROLE_MASTER_SELECT_BIT)) : ctrl_w;

  // read mux
  wire [7:0] stat_val = {done_q, write_collision_flag_q, 5'h00, dbl_q};
  wire [7:0] rd_val = hit_ctrl ? ctrl_q :
                      hit_stat ? stat_val :
                      hit_data ? rx_q :
                      hit_pin ? {3'h0, pin_q} : 8'h00;

  // pin drive values
  wire mosi_oe_d = master_on & pin_q[spi_port_pkg::DIR_MOSI_BIT];
  // data out only by software direction
  wire miso_oe_d = slave_on & pin_q[spi_port_pkg::DIR_MISO_BIT];
  wire sck_oe_d = master_on & pin_q[spi_port_pkg::DIR_SCK_BIT];
  // select never driven in slave role
  // select is a plain output in master role only when its direction bit is set
  wire ss_oe_d = master_on & pin_q[spi_port_pkg::DIR_SS_BIT];
  wire irq_d = done_q & ie & global_irq_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= spi_port_pkg::CTRL_RST;
      pin_q <= spi_port_pkg::PIN_RST;
      dbl_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr & hit_pin) begin
        pin_q <= pwdata[4:0];
      end
      if (wr & hit_stat) begin
        dbl_q <= pwdata[spi_port_pkg::DBL_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      done_q <= done_d;
      write_collision_flag_q <= write_collision_flag_d;
      arm_q <= arm_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_p_q <= 1'b1;
      sck_p_q <= 1'b0;
    end else begin
      ss_p_q <= ss_s;
      sck_p_q <= sck_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (abort | start) begin
      cnt_q <= 4'h0;
    end else if (tick) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // master clock stops after the last edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= spi_port_pkg::ST_IDLE;
    end else if (abort | byte_done) begin
      state_q <= spi_port_pkg::ST_IDLE;
    end else if (m_start) begin
      state_q <= spi_port_pkg::ST_SHIFT;
    end
  end

  // half period reload from rate table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 7'h01;
    end else if (m_start | m_tick) begin
      half_q <= spi_port_pkg::HALF_TBL[rate_idx];
    end else if (shifting) begin
      half_q <= half_q - 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
    end else if (!shifting | abort) begin
      sck_q <= pol;
    end else if (m_tick) begin
      sck_q <= ~sck_q;
    end
  end

  // sample on sample edge, shift on setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbit_q <= 1'b0;
      sh_q <= spi_port_pkg::BYTE_RST;
      rx_q <= spi_port_pkg::BYTE_RST;
    end else begin
      if (tick & samp) begin
        rbit_q <= in_bit;
      end
      if (start) begin
        sh_q <= pwdata[7:0];
      end else if (do_shift & ~abort) begin
        sh_q <= sh_next;
      end
      if (byte_done) begin
        rx_q <= sh_next;
      end
    end
  end

  // apb answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= setup ? {24'h000000, rd_val} : prdata;
      pready <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      ss_o <= 1'b0;
      ss_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      sck_o <= sck_q;
      sck_oe <= sck_oe_d;
      mosi_o <= out_bit;
      mosi_oe <= mosi_oe_d;
      miso_o <= out_bit;
      miso_oe <= miso_oe_d;
      ss_o <= pin_q[spi_port_pkg::SS_VAL_BIT];
      ss_oe <= ss_oe_d;
      irq <= irq_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_master_start;
    m_start && !abort;
  endsequence
  sequence s_shift_begun;
    shifting && cnt_q == 4'h0 && half_q == spi_port_pkg::HALF_TBL[$past(rate_idx)];
  endsequence

  a_start_runs:
    assert property (s_master_start |=> s_shift_begun)
      else $error("master start did not begin shifting");
  a_contend_drop:
    assert property (contend |=> !ctrl_q[spi_port_pkg::ROLE_MASTER_SELECT_BIT] && done_q)
      else $error("contention did not drop master role");
  a_irq_gate:
    assert property (irq |-> $past(done_q) && $past(ie) && $past(global_irq_en))
      else $error("interrupt without all enables");
  a_disabled_idle:
    assert property (!en |=> !shifting && cnt_q == 4'h0)
      else $error("activity while disabled");
  a_ss_reset:
    assert property (ss_rise |=> cnt_q == 4'h0 && !shifting)
      else $error("select release did not reset counter");
  a_slave_ss_in:
    assert property (slave_on |=> !ss_oe)
      else $error("select driven in slave role");
  a_write_collision_flag_set:
    assert property (data_wr && busy |=> write_collision_flag_q && sh_q == $past(do_shift && !abort ? sh_next : sh_q))
      else $error("collision not flagged");
  a_byte_done:
    assert property (byte_done |=> done_q && rx_q == $past(sh_next) && cnt_q == 4'h0)
      else $error("byte end not reported");
  a_ss_gpio:
    assert property (master_on && pin_q[spi_port_pkg::DIR_SS_BIT] |=> ss_oe && ss_o == $past(pin_q[4]))
      else $error("select output not following setting");
  a_passive_slave:
    assert property (slave_on && ss_s && ss_p_q && !start |=> cnt_q == $past(cnt_q) && $stable(rbit_q))
      else $error("deselected slave took data");
endmodule : spi_port
`default_nettype wire

//--- testbench/spi_peer.sv
// behavioural serial peer on the far side of the master link
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
  // link
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // format and data
  input wire logic clock_idle_polarity,
  input wire logic clock_sample_phase,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  int n = 0;
  wire logic ph = sck ^ clock_idle_polarity;
  function automatic logic bit_at(input int k);
    logic [2:0] j;
    j = k[2:0];
    return lsb ? tx[j] : tx[3'h7 - j];
  endfunction : bit_at
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    n = 0;
    miso = bit_at(0);
  end
  // released line shows no stale value
  always @(posedge sel_n) miso = ~miso;
  always @(ph) if (!sel_n) begin
    if (ph ^ clock_sample_phase) begin
      rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      n++;
    end else begin
      miso = bit_at(n);
    end
  end
endmodule : spi_peer
`default_nettype wire

//--- testbench/spi_master_slave_port_test.sv
// bench: master transfers over all modes and rates, collision, contention
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_test;
  logic pclk, presetn, psel, penable, pwrite, global_irq_en, irq_vector_ack;
  logic ss_drv, clock_idle_polarity, clock_sample_phase, lsb, peer_miso, pready, pslverr, irq;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
  logic [7:0] paddr, ptx, prx, dtx, cv;
  logic [31:0] pwdata, prdata, rs;
  logic [33:0] q[$];
  logic [33:0] e;
  int n_fail = 0, num_checks = 0, cyc = 0, t;
  wire logic sck_w = sck_oe ? sck_o : clock_idle_polarity;
  wire logic mosi_w = mosi_oe ? mosi_o : ~mosi_o;
  wire logic miso_w = miso_oe ? miso_o : peer_miso;
  wire logic ss_w = ss_oe ? ss_o : ss_drv;
  logic [7:0] divs [8] = '{8'h04, 8'h10, 8'h40, 8'h80, 8'h02, 8'h08, 8'h20, 8'h40};
  spi_port dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_i(ss_w),
    .ss_o(ss_o), .ss_oe(ss_oe), .global_irq_en(global_irq_en), .irq_vector_ack(irq_vector_ack),
    .irq(irq));
  spi_peer peer (.sck(sck_w), .mosi(mosi_w), .sel_n(ss_w), .miso(peer_miso), .clock_idle_polarity(clock_idle_polarity),
    .clock_sample_phase(clock_sample_phase), .lsb(lsb), .tx(ptx), .rx(prx));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [32:0] x,
      input logic c);
    @(posedge pclk);
    q.push_back({c, x});
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  always #25 pclk = ~pclk;
  always @(posedge pclk) if (psel && penable && pready) begin
    e = q.pop_front();
    if (e[33]) check("apb", {pslverr, pwrite ? 32'h00000000 : prdata}, e[32:0]);
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, irq_vector_ack, clock_idle_polarity, clock_sample_phase, lsb} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    global_irq_en = 1'b1;
    ss_drv = 1'b1;
    ptx = 8'h00;
    rs = 32'hCC6E3778;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(spi_port_pkg::CTRL_OFS, 1'b0, 8'h00, 33'h000000000, 1'b1);
    apb(8'h10, 1'b0, 8'h00, 33'h100000000, 1'b1);
    apb(spi_port_pkg::PIN_OFS, 1'b1, 8'h0F, 33'h000000000, 1'b1);
    repeat (3) @(posedge pclk);
    check("oe", {sck_oe, mosi_oe, miso_oe, ss_oe}, 33'h000000000);
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      dtx = rs[7:0];
      cv = {2'b11, i[2] ^ i[0], 1'b1, i[0], i[1], i[1:0]};
      clock_idle_polarity <= cv[3];
      clock_sample_phase <= cv[2];
      lsb <= cv[5];
      ptx <= rs[15:8];
      apb(spi_port_pkg::CTRL_OFS, 1'b1, cv, 33'h000000000, 1'b1);
      apb(spi_port_pkg::STAT_OFS, 1'b1, {7'h00, i[2]}, 33'h000000000, 1'b1);
      apb(spi_port_pkg::PIN_OFS, 1'b1, 8'h0D, 33'h000000000, 1'b1);
      apb(spi_port_pkg::DATA_OFS, 1'b1, dtx, 33'h000000000, 1'b1);
      t = 0;
      @(posedge pclk);
      while (sck_o === cv[3]) @(posedge pclk);
      while (sck_o !== cv[3]) begin
        @(posedge pclk);
        t++;
      end
      check("half", 33'(t), {25'h0000000, divs[i] >> 1});
      if (i == 2) apb(spi_port_pkg::DATA_OFS, 1'b1, ~dtx, 33'h000000000, 1'b1);
      while (irq !== 1'b1) @(posedge pclk);
      check("sck idle", sck_o, cv[3]);
      apb(spi_port_pkg::STAT_OFS, 1'b0, 8'h00, {25'h0000000, 1'b1, i == 2, 5'h00, i[2]}, 1'b1);
      // readback needs four clocks per half period: miso crosses the pin synchroniser
      apb(spi_port_pkg::DATA_OFS, 1'b0, 8'h00, {25'h0000000, ptx}, i[1:0] != 2'b00);
      check("peer rx", prx, dtx);
      repeat (2) @(posedge pclk);
      check("irq clear", irq, 1'b0);
      apb(spi_port_pkg::STAT_OFS, 1'b0, 8'h00, {32'h00000000, i[2]}, 1'b1);
      apb(spi_port_pkg::PIN_OFS, 1'b1, 8'h1D, 33'h000000000, 1'b1);
    end
    apb(spi_port_pkg::PIN_OFS, 1'b1, 8'h05, 33'h000000000, 1'b1);
    apb(spi_port_pkg::CTRL_OFS, 1'b1, 8'hD0, 33'h000000000, 1'b1);
    global_irq_en <= 1'b0;
    ss_drv <= 1'b0;
    repeat (8) @(posedge pclk);
    check("irq masked", irq, 1'b0);
    global_irq_en <= 1'b1;
    repeat (3) @(posedge pclk);
    check("irq", irq, 1'b1);
    apb(spi_port_pkg::CTRL_OFS, 1'b0, 8'h00, 33'h0000000C0, 1'b1);
    irq_vector_ack <= 1'b1;
    ss_drv <= 1'b1;
    @(posedge pclk);
    irq_vector_ack <= 1'b0;
    apb(spi_port_pkg::STAT_OFS, 1'b0, 8'h00, 33'h000000001, 1'b1);
    apb(spi_port_pkg::CTRL_OFS, 1'b1, 8'hD0, 33'h000000000, 1'b1);
    apb(spi_port_pkg::CTRL_OFS, 1'b0, 8'h00, 33'h0000000D0, 1'b1);
    @(posedge pclk);
    stop_test();
  end
endmodule : spi_master_slave_port_test
`default_nettype wire
